// File: cbd_pkg.sv
package cbd_pkg;

    // register map, byte offsets on the register bus
    localparam int          APB_AW       = 4;
    localparam logic [3:0]  OFS_DPAGE    = 4'h0;
    localparam logic [3:0]  OFS_STATUS   = 4'h4;
    localparam logic [7:0]  DPAGE_RST    = 8'h00;

    // status word field positions
    localparam int          ST_BS_LSB    = 0;
    localparam int          ST_EXT_BIT   = 2;
    localparam int          ST_FSM_LSB   = 4;
    localparam int          ST_HOLD_LSB  = 8;

    // quarter phases of one bus cycle (four oscillator periods)
    localparam logic [1:0]  PH_ADDR      = 2'h0;
    localparam logic [1:0]  PH_QHI       = 2'h1;
    localparam logic [1:0]  PH_BOTH      = 2'h2;
    localparam logic [1:0]  PH_EHI       = 2'h3;
    localparam logic [1:0]  PH_STEP      = 2'h1;

    // bus hand-over limits
    localparam int          HOLD_W       = 4;
    localparam logic [3:0]  HOLD_LIMIT   = 4'hf;
    localparam logic [3:0]  HOLD_STEP    = 4'h1;
    localparam logic [1:0]  IDLE_CLEAR   = 2'h2;
    localparam logic [1:0]  IDLE_STEP    = 2'h1;

    // bus-state output codes
    localparam logic [1:0]  BS_CPU       = 2'h0;
    localparam logic [1:0]  BS_GRANT     = 2'h3;

    // pclk cycles per quarter when the on-chip oscillator runs alone
    localparam int          OSC_DIV_DEF  = 2;

    typedef enum logic [2:0] {
        FSM_RUN,
        FSM_GRANT,
        FSM_DMA,
        FSM_REL_DEAD,
        FSM_PRE_DEAD,
        FSM_REFRESH,
        FSM_POST_DEAD
    } cbd_fsm_e;

endpackage : cbd_pkg

// File: cbd_sync.sv
`timescale 1ns/1ps
module cbd_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    import cbd_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cbd_sync_s;

    cbd_sync_s st_ff;
    cbd_sync_s nxt_st;

    // two stages; only the second is visible
    always_comb
    begin
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign sync_out = st_ff.s2;

endmodule : cbd_sync

// File: cbd_qtick.sv
`timescale 1ns/1ps
module cbd_qtick #(
    parameter int OSC_DIV = cbd_pkg::OSC_DIV_DEF
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ext_sel,
    input  wire logic osc_sync,
    output logic      qtick
);
    import cbd_pkg::*;

    localparam int DW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(OSC_DIV - 1);
    localparam logic [DW-1:0] DIV_STEP = DW'(1);

    typedef struct packed {
        logic          osc_d;
        logic [DW-1:0] div;
    } cbd_qtick_s;

    cbd_qtick_s st_ff;
    cbd_qtick_s nxt_st;

    // internal divider stands in for the crystal; external mode uses osc edges
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.osc_d = osc_sync;
        nxt_st.div   = (st_ff.div == DIV_LAST) ? '0 : st_ff.div + DIV_STEP;
        qtick        = ext_sel ? (osc_sync & ~st_ff.osc_d) : (st_ff.div == DIV_LAST);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

endmodule : cbd_qtick

// File: cbd_bus_ctrl.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module cbd_bus_ctrl #(
    parameter int         OSC_DIV  = cbd_pkg::OSC_DIV_DEF,
    parameter logic [3:0] HOLD_MAX = cbd_pkg::HOLD_LIMIT
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [cbd_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       osc_in,
    input  wire logic                       xtal_grounded_in,
    input  wire logic                       memory_ready_in,
    input  wire logic                       dma_bus_request_n_in,
    input  wire logic [7:0]                 data_in,
    input  wire logic [15:0]                cpu_addr_in,
    input  wire logic                       cpu_direct_in,
    output logic                            e_clk_out,
    output logic                            q_clk_out,
    output logic [15:0]                     addr_out,
    output logic                            addr_drive_en_out,
    output logic [7:0]                      rd_data_out,
    output logic                            cpu_clk_en_out,
    output logic [1:0]                      bus_state_out,
    output logic                            mem_valid_out
);
    import cbd_pkg::*;

    // edges the strap needs to pass the pin synchroniser; the synchroniser is
    // held in reset too, so its output is only valid from the third edge on
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] STRAP_STEP   = 2'h1;

    typedef struct packed {
        logic        strap_done;
        logic [1:0]  strap_cnt;
        logic        ext_osc;
        logic [1:0]  phase;
        cbd_fsm_e    fsm;
        logic [3:0]  hold;
        logic [1:0]  idle;
        logic [7:0]  dpage;
        logic        e;
        logic        q;
        logic [15:0] addr;
        logic        addr_en;
        logic [7:0]  rd_data;
        logic        cpu_en;
        logic [1:0]  bs;
        logic        vma;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cbd_state_s;

    cbd_state_s  st_ff;
    cbd_state_s  nxt_st;
    logic [11:0] pin_sync;
    logic        osc_s;
    logic        xtal_gnd_s;
    logic        ready_s;
    logic        req_s;
    logic [7:0]  data_s;
    logic        qtick;
    logic        stretch;
    logic        cyc_end;
    logic [3:0]  hold_inc;
    logic [31:0] status_w;

    // cycles in which memory is really accessed (stretch allowed)
    function automatic logic is_valid(cbd_fsm_e f);
        is_valid = (f == FSM_RUN) || (f == FSM_REFRESH) || (f == FSM_DMA);
    endfunction : is_valid

    // cycles owned by the processor core
    function automatic logic is_cpu(cbd_fsm_e f);
        is_cpu = (f == FSM_RUN) || (f == FSM_REFRESH);
    endfunction : is_cpu

    // cycles in which this side drives address lines
    function automatic logic drives(cbd_fsm_e f);
        drives = (f == FSM_RUN) || (f == FSM_REFRESH) || (f == FSM_POST_DEAD);
    endfunction : drives

    // oscillator, strap, ready, request and data pins pass two flops; core address and direct select do not
    cbd_sync #(
        .W        (12)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({osc_in, xtal_grounded_in, memory_ready_in,
                    dma_bus_request_n_in, data_in}),
        .sync_out (pin_sync)
    );

    assign osc_s      = pin_sync[11];
    assign xtal_gnd_s = pin_sync[10];
    assign ready_s    = pin_sync[9];
    assign req_s      = ~pin_sync[8];
    assign data_s     = pin_sync[7:0];

    // quarter-cycle ticks from oscillator or internal divider
    cbd_qtick #(
        .OSC_DIV  (OSC_DIV)
    ) u_qtick (
        .pclk     (pclk),
        .presetn  (presetn),
        .ext_sel  (st_ff.ext_osc),
        .osc_sync (osc_s),
        .qtick    (qtick)
    );

    // status word seen by software
    always_comb
    begin
        status_w                            = '0;
        status_w[ST_BS_LSB +: 2]            = st_ff.bs;
        status_w[ST_EXT_BIT]                = st_ff.ext_osc;
        status_w[ST_FSM_LSB +: 3]           = st_ff.fsm;
        status_w[ST_HOLD_LSB +: HOLD_W]     = st_ff.hold;
    end

    // next-state logic: clocks, hand-over sequencer, register bus
    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.cpu_en = 1'b0;
        cyc_end       = 1'b0;
        hold_inc      = st_ff.hold + HOLD_STEP;

        // strap caught once, after the synchroniser has filled with the pin
        if (!st_ff.strap_done)
        begin
            nxt_st.strap_cnt = st_ff.strap_cnt + STRAP_STEP;
            if (st_ff.strap_cnt == STRAP_SETTLE)
            begin
                nxt_st.strap_done = 1'b1;
                nxt_st.ext_osc    = xtal_gnd_s;
            end
        end

        // hold the late quarter while ready is low on a valid access
        stretch = !ready_s && st_ff.vma && (st_ff.phase == PH_EHI);

        if (qtick && st_ff.strap_done && !stretch)
        begin
            nxt_st.phase = st_ff.phase + PH_STEP;
            cyc_end      = (st_ff.phase == PH_EHI);
        end

        // quadrature clock leads bus clock by one quarter
        nxt_st.q = (nxt_st.phase == PH_QHI) || (nxt_st.phase == PH_BOTH);
        nxt_st.e = (nxt_st.phase == PH_BOTH) || (nxt_st.phase == PH_EHI);

        if (cyc_end)
        begin
            if (is_cpu(st_ff.fsm))
            begin
                nxt_st.cpu_en  = 1'b1;
                nxt_st.rd_data = data_s;
            end
            nxt_st.idle = '0;
            case (st_ff.fsm)
                FSM_RUN:
                begin
                    if (req_s)
                        nxt_st.fsm = (st_ff.hold >= HOLD_MAX) ? FSM_PRE_DEAD
                                                              : FSM_GRANT;
                    else
                    begin
                        nxt_st.idle = (st_ff.idle >= IDLE_CLEAR) ? st_ff.idle
                                                                 : st_ff.idle + IDLE_STEP;
                        if (nxt_st.idle >= IDLE_CLEAR)
                            nxt_st.hold = '0;
                    end
                end
                FSM_GRANT, FSM_DMA:
                begin
                    nxt_st.hold = hold_inc;
                    if (!req_s)
                        nxt_st.fsm = FSM_REL_DEAD;
                    else if (hold_inc >= HOLD_MAX)
                        nxt_st.fsm = FSM_PRE_DEAD;
                    else
                        nxt_st.fsm = FSM_DMA;
                end
                FSM_REL_DEAD:
                    nxt_st.fsm = FSM_RUN;
                FSM_PRE_DEAD:
                    nxt_st.fsm = FSM_REFRESH;
                FSM_REFRESH:
                begin
                    nxt_st.hold = '0;
                    nxt_st.fsm  = FSM_POST_DEAD;
                end
                FSM_POST_DEAD:
                    nxt_st.fsm = req_s ? FSM_GRANT : FSM_RUN;
                default:
                    nxt_st.fsm = FSM_RUN;
            endcase

            // new address at cycle start, ahead of the quadrature rise
            if (cpu_direct_in)
                nxt_st.addr = {st_ff.dpage, cpu_addr_in[7:0]};
            else
                nxt_st.addr = cpu_addr_in;
            nxt_st.addr_en = drives(nxt_st.fsm);
            nxt_st.vma     = is_valid(nxt_st.fsm);
            nxt_st.bs      = ((nxt_st.fsm == FSM_GRANT) || (nxt_st.fsm == FSM_DMA))
                             ? BS_GRANT : BS_CPU;
        end

        // register bus: decode in first access cycle, answer in second
        nxt_st.pready  = psel && penable && !st_ff.pready;
        nxt_st.pslverr = 1'b0;
        if (psel && penable && !st_ff.pready)
        begin
            case (paddr)
                OFS_DPAGE:
                    nxt_st.prdata = pwrite ? st_ff.prdata : {24'h000000, st_ff.dpage};
                OFS_STATUS:
                begin
                    nxt_st.prdata  = pwrite ? st_ff.prdata : status_w;
                    nxt_st.pslverr = pwrite;
                end
                default:
                begin
                    nxt_st.prdata  = 32'h00000000;
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end
        // write lands on the edge that completes the transfer
        if (psel && penable && st_ff.pready && pwrite && (paddr == OFS_DPAGE))
            nxt_st.dpage = pwdata[7:0];
    end

    // state register; page register cleared by reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff       <= '0;
            st_ff.dpage <= DPAGE_RST;
            st_ff.vma   <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    // all outputs straight from the state register
    assign prdata            = st_ff.prdata;
    assign pready            = st_ff.pready;
    assign pslverr           = st_ff.pslverr;
    assign e_clk_out         = st_ff.e;
    assign q_clk_out         = st_ff.q;
    assign addr_out          = st_ff.addr;
    assign addr_drive_en_out = st_ff.addr_en;
    assign rd_data_out       = st_ff.rd_data;
    assign cpu_clk_en_out    = st_ff.cpu_en;
    assign bus_state_out     = st_ff.bs;
    assign mem_valid_out     = st_ff.vma;

    // checks on the clocking and hand-over sequence
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    q_leads_e_a: assert property ($rose(e_clk_out) |-> q_clk_out)
        else $error("bus clock rose without quadrature clock high");

    addr_stable_a: assert property (q_clk_out |-> $stable(addr_out))
        else $error("address moved while quadrature clock high");

    stretch_hold_a: assert property (qtick && !ready_s && st_ff.vma
                                     && st_ff.phase == PH_EHI |=> st_ff.phase == PH_EHI)
        else $error("valid access not stretched while ready low");

    dead_free_a: assert property (qtick && !st_ff.vma && st_ff.strap_done
                                  && st_ff.phase == PH_EHI |=> st_ff.phase == PH_ADDR)
        else $error("dead cycle was stretched");

    grant_dead_a: assert property ($rose(bus_state_out[1]) |-> !mem_valid_out
                                   && bus_state_out == BS_GRANT)
        else $error("grant did not open with a dead cycle");

    no_cpu_dma_a: assert property (bus_state_out == BS_GRANT && $past(bus_state_out)
                                   == BS_GRANT |-> !cpu_clk_en_out)
        else $error("processor clock ran during hand-over");

    hold_bound_a: assert property ((bus_state_out == BS_GRANT)
                                   |-> st_ff.hold < HOLD_MAX)
        else $error("bus held beyond the refresh limit");

    refresh_frame_a: assert property ($fell(st_ff.fsm == FSM_REFRESH)
                                      |-> st_ff.fsm == FSM_POST_DEAD && !mem_valid_out)
        else $error("refresh not followed by dead cycle");

    release_gap_a: assert property ($fell(bus_state_out[1]) |-> !addr_drive_en_out)
        else $error("address driven right after grant fell");

    run_idle_a: assert property (st_ff.fsm == FSM_RUN |-> bus_state_out == BS_CPU)
        else $error("bus-state high in normal running");

    page_addr_a: assert property (cyc_end && cpu_direct_in |=> addr_out[15:8]
                                  == $past(st_ff.dpage))
        else $error("direct access high byte not from page register");

    grant_c: cover property ($rose(bus_state_out == BS_GRANT));
    refresh_c: cover property (st_ff.fsm == FSM_REFRESH && cpu_clk_en_out);
    stretch_c: cover property (stretch && qtick);
    apb_err_c: cover property (pready && pslverr);
    strap_ext_c: cover property (st_ff.strap_done && st_ff.ext_osc);

    strap_keep_a: assert property (st_ff.strap_done && $past(st_ff.strap_done)
                                   |-> $stable(st_ff.ext_osc))
        else $error("timing source changed after the strap was taken");

endmodule : cbd_bus_ctrl

// File: cbd_far_model.sv
`timescale 1ns/1ps
module cbd_far_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        e_clk,
    input  wire logic [1:0]  bus_state,
    input  wire logic        mem_valid,
    input  wire logic [15:0] addr,
    input  wire logic [3:0]  stall_len,
    input  wire logic        dma_want,
    output logic             mem_ready,
    output logic             bus_req_n,
    output logic [7:0]       rd_bus
);
    logic       e_d;
    logic       owns;
    logic [3:0] stall_cnt;
    wire        e_rise = e_clk & ~e_d;

    // slow memory keeps ready low for a while after each bus clock rise
    assign mem_ready = (stall_cnt == 4'h0);

    // request, ownership and read data of memory and master
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            e_d       <= 1'b0;
            owns      <= 1'b0;
            stall_cnt <= 4'h0;
            bus_req_n <= 1'b1;
            rd_bus    <= 8'h00;
        end
        else
        begin
            e_d       <= e_clk;
            stall_cnt <= e_rise ? stall_len : (stall_cnt != 4'h0) ? stall_cnt - 4'h1 : 4'h0;
            if (e_rise)
                bus_req_n <= ~dma_want;              // request moves at bus clock rise
            owns <= (bus_state == 2'h3);             // master lets go once grant drops
            if (e_rise && (mem_valid || owns))
                rd_bus <= addr[7:0] ^ 8'h5a;         // only qualified cycles get data
            else if (!e_clk || !(mem_valid || owns))
                rd_bus <= ~rd_bus;                   // released bus inverts every cycle rather than holding old data
        end
    end
endmodule : cbd_far_model

// File: test_cpu_bus_clock_dma_handover.sv
`timescale 1ns/1ps
module test_cpu_bus_clock_dma_handover;
    import cbd_pkg::*;

    localparam int         OSC     = 2;
    localparam int         OSC_EXT = 8;
    localparam logic [3:0] HOLD    = 4'hf;

    typedef struct {
        logic        wr;
        logic [31:0] d;
        logic        err;
    } cbd_apb_exp_s;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [3:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        osc_in, xtal_grounded_in, memory_ready_in, dma_bus_request_n_in;
    logic [7:0]  data_in, rd_data_out, dp_val;
    logic [15:0] cpu_addr_in, addr_out;
    logic        cpu_direct_in, e_clk_out, q_clk_out, addr_drive_en_out;
    logic        cpu_clk_en_out, mem_valid_out, mv, ade, dma_want, dir_ok, new_addr;
    logic [1:0]  bus_state_out, bs;
    logic [3:0]  stall;
    int          len, qe, pl, k, run, np, slow, fails, n_compared, guard;
    cbd_apb_exp_s apbq[$];
    cbd_apb_exp_s exp_apb;
    logic [7:0]  rdq[$];

    cbd_bus_ctrl #(.OSC_DIV(OSC), .HOLD_MAX(HOLD)) u_cbd_bus_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_in(osc_in), .xtal_grounded_in(xtal_grounded_in),
        .memory_ready_in(memory_ready_in), .dma_bus_request_n_in(dma_bus_request_n_in),
        .data_in(data_in), .cpu_addr_in(cpu_addr_in), .cpu_direct_in(cpu_direct_in),
        .e_clk_out(e_clk_out), .q_clk_out(q_clk_out), .addr_out(addr_out),
        .addr_drive_en_out(addr_drive_en_out), .rd_data_out(rd_data_out),
        .cpu_clk_en_out(cpu_clk_en_out), .bus_state_out(bus_state_out),
        .mem_valid_out(mem_valid_out));

    cbd_far_model u_cbd_far_model (
        .pclk(pclk), .presetn(presetn), .e_clk(e_clk_out), .bus_state(bus_state_out),
        .mem_valid(mem_valid_out), .addr(addr_out), .stall_len(stall),
        .dma_want(dma_want), .mem_ready(memory_ready_in),
        .bus_req_n(dma_bus_request_n_in), .rd_bus(data_in));

    // bench clock and the external oscillator pin
    always #50 pclk = ~pclk;
    always #400 osc_in = ~osc_in;

    // fresh core address once the previous one has been checked
    always @(posedge pclk)
        if (new_addr)
        begin
            cpu_addr_in   <= 16'($urandom);
            cpu_direct_in <= dir_ok & 1'($urandom);
            new_addr      <= 1'b0;
        end

    // answer watchers: register reads and data captured per processor cycle
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && apbq.size() > 0)
        begin
            exp_apb = apbq.pop_front();
            check({31'h0, pslverr}, {31'h0, exp_apb.err});
            if (!exp_apb.wr)
                check(prdata, exp_apb.d);
        end
        if (cpu_clk_en_out === 1'b1 && rdq.size() > 0)
            check({24'h0, rd_data_out}, {24'h0, rdq.pop_front()});
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic hang_check;
        guard++;
        if (guard > 20000)
        begin
            check(guard, 0);
            complete_run();
        end
    endtask : hang_check

    task automatic tick;
        @(negedge pclk);
        hang_check();
    endtask : tick

    task automatic do_reset(input logic strap);
        @(posedge pclk);
        presetn          <= 1'b0;
        xtal_grounded_in <= strap;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] exp_d, input logic exp_e);
        apbq.push_back('{wr, exp_d, exp_e});
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            hang_check();
        end
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_addr;
        if (cpu_direct_in === 1'b1)
            check({24'h0, addr_out[15:8]}, {24'h0, dp_val});
        else
            check({16'h0, addr_out}, {16'h0, cpu_addr_in});
        rdq.push_back(cpu_addr_in[7:0] ^ 8'h5a);
        new_addr = 1'b1;
    endtask : check_addr

    task automatic wait_fall;
        logic pe;
        do
        begin
            pe = e_clk_out;
            tick();
        end
        while (!(pe === 1'b1 && e_clk_out === 1'b0));
    endtask : wait_fall

    // one bus cycle from bus clock fall to the next fall
    task automatic bus_cycle;
        int   qa;
        logic pe;
        logic pq;
        len = 0;
        qe  = 0;
        pl  = 0;
        qa  = 0;
        bs  = bus_state_out;
        mv  = mem_valid_out;
        ade = addr_drive_en_out;
        do
        begin
            pe = e_clk_out;
            pq = q_clk_out;
            tick();
            len++;
            pl += int'(cpu_clk_en_out === 1'b1);
            if (pq === 1'b0 && q_clk_out === 1'b1)
            begin
                qa = len;
                if (ade === 1'b1 && mv === 1'b1 && bs === BS_CPU)
                    check_addr();
            end
            if (pe === 1'b0 && e_clk_out === 1'b1)
                qe = len - qa;
        end
        while (!(pe === 1'b1 && e_clk_out === 1'b0));
    endtask : bus_cycle

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, osc_in, xtal_grounded_in} = 7'h0;
        {paddr, pwdata, cpu_addr_in, cpu_direct_in} = 53'h0;
        {dma_want, dir_ok, new_addr, stall, fails, n_compared, guard} = 0;
        void'($urandom(29546));
        do_reset(1'b0);
        // reset values, page register, refused accesses
        check({30'h0, bus_state_out}, 32'h0);
        apb(1'b0, OFS_DPAGE, 32'h0, 32'h0, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0);
        dp_val = 8'($urandom);
        apb(1'b1, OFS_DPAGE, {24'($urandom), dp_val}, 32'h0, 1'b0);
        apb(1'b0, OFS_DPAGE, 32'h0, {24'h0, dp_val}, 1'b0);
        apb(1'b0, 4'h8, 32'h0, 32'h0, 1'b1);
        apb(1'b1, OFS_STATUS, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0);
        $display("test registers done");
        // unstretched cycles with crystal timing
        dir_ok = 1'b1;
        wait_fall();
        repeat (6)
        begin
            bus_cycle();
            check(len, 4 * OSC);
            check(qe, OSC);
            check({30'h0, bs}, {30'h0, BS_CPU});
        end
        $display("test bus clocks done");
        // slow memory stretches in whole quarters, one processor tick each
        stall = 4'h6;
        repeat (3)
        begin
            bus_cycle();
            check(int'(len > 4 * OSC && len % OSC == 0), 1);
            check(pl, 1);
        end
        $display("test stretch done");
        // hand-over to a master on slow memory, forced refresh, release
        dir_ok   = 1'b0;
        dma_want = 1'b1;
        k = 0;
        do
        begin
            bus_cycle();
            k++;
        end
        while (bs !== BS_GRANT && k < 6);
        check(len, 4 * OSC);
        check({31'h0, mv}, 32'h0);
        {run, np, slow} = {32'd1, 32'd0, 32'd0};
        do
        begin
            bus_cycle();
            if (bs === BS_GRANT)
            begin
                run++;
                np += pl;
                slow += int'(len > 4 * OSC);
            end
        end
        while (bs === BS_GRANT && run < 40);
        check(run, HOLD);
        check(np, 0);
        check(slow, HOLD - 1);
        check({31'h0, mv}, 32'h0);
        check(len, 4 * OSC);
        bus_cycle();
        check({30'h0, bs, mv, pl[0]}, 32'h3);
        bus_cycle();
        check({29'h0, bs, mv, ade}, 32'h1);
        bus_cycle();
        check({30'h0, bs}, {30'h0, BS_GRANT});
        dma_want = 1'b0;
        k = 0;
        do
        begin
            bus_cycle();
            k++;
        end
        while (bs === BS_GRANT && k < 8);
        check({30'h0, mv, ade}, 32'h0);
        bus_cycle();
        check({29'h0, bs, mv, ade}, 32'h3);
        check(pl, 1);
        apb(1'b0, OFS_STATUS, 32'h0, 32'h2 << ST_HOLD_LSB, 1'b0);
        wait_fall();
        apb(1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0);
        $display("test bus hand-over done");
        // external timing source on the oscillator pin
        stall = 4'h0;
        do_reset(1'b1);
        wait_fall();
        repeat (2)
        begin
            bus_cycle();
            check(len, 4 * OSC_EXT);
            check(qe, OSC_EXT);
        end
        apb(1'b0, OFS_STATUS, 32'h0, 32'h1 << ST_EXT_BIT, 1'b0);
        $display("test external oscillator done");
        complete_run();
    end
endmodule : test_cpu_bus_clock_dma_handover
